//--- include/gbs_pkg.sv
// Purpose: Constants and types for the GPIO bit set/clear register block
// Assumes: 32-bit classic Wishbone, byte addresses, one clock domain
// Notes: Pin n of every port sits at bit 16+n (output), 24+n (direction), n (input)

package gbs_pkg;

	// ==========================================================
	// Register byte addresses
	localparam logic [31:0] ADR_P0_DATA = 32'hFFFF_0D20;
	localparam logic [31:0] ADR_P0_SET = 32'hFFFF_0D24;
	localparam logic [31:0] ADR_P0_CLR = 32'hFFFF_0D28;
	localparam logic [31:0] ADR_P1_DATA = 32'hFFFF_0D30;
	localparam logic [31:0] ADR_P1_SET = 32'hFFFF_0D34;
	localparam logic [31:0] ADR_P1_CLR = 32'hFFFF_0D38;
	localparam logic [31:0] ADR_P2_DATA = 32'hFFFF_0D40;
	localparam logic [31:0] ADR_P2_SET = 32'hFFFF_0D44;
	localparam logic [31:0] ADR_P2_CLR = 32'hFFFF_0D48;

	// ==========================================================
	// Field positions inside a register word
	localparam int unsigned PIN_W = 7;
	localparam int unsigned IN_LSB = 0;
	localparam int unsigned OUT_LSB = 16;
	localparam int unsigned DIR_LSB = 24;
	localparam int unsigned OUT_LANE = 2;
	localparam int unsigned DIR_LANE = 3;

	// ==========================================================
	// Which pins exist per port
	localparam logic [6:0] P0_OUT_MASK = 7'h1F;
	localparam logic [6:0] P1_OUT_MASK = 7'h03;
	localparam logic [6:0] P2_OUT_MASK = 7'h63;
	localparam logic [6:0] P0_DIR_MASK = 7'h1F;
	localparam logic [6:0] P1_DIR_MASK = 7'h03;
	localparam logic [6:0] P2_DIR_MASK = 7'h73;

	// ==========================================================
	// Reset values
	localparam logic [6:0] RST_OUT = 7'h00;
	localparam logic [6:0] RST_DIR = 7'h00;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

	// ==========================================================
	// Access kinds, one-hot
	typedef enum logic [3:0] {
		GBS_ACC_NONE = 4'b0001,
		GBS_ACC_DATA = 4'b0010,
		GBS_ACC_SET = 4'b0100,
		GBS_ACC_CLR = 4'b1000
	} gbs_acc_t;

endpackage

//--- design/gbs_gpio_set_clear.sv
// Purpose: Port data registers plus write-only set and clear registers for three GPIO ports
// Assumes: Classic Wishbone slave, synchronous active-high reset, 10 MHz clock
// Notes: Pin pads resolve the wire from pin_o and oe_n_o outside this module
//
// Overview of operation
// - Port 0 set write, ones in bits 16..20 drive pins 0..4 high.
// - Port 1 set write, ones in bits 16..17 drive pins 0..1 high.
// - Port 2 set write, ones in bits 16,17,21,22 drive pins 0,1,5,6 high.
// - Port 0 clear write, ones in bits 16..20 drive pins 0..4 low.
// - Port 1 clear write, ones in bits 16..17 drive pins 0..1 low.
// - Port 2 clear write, ones in bits 16,17,21,22 drive pins 0,1,5,6 low.
// - Zero bits in set or clear writes leave their pins unchanged.
// - Single pins change without software touching other pins of the port.
// - A pin is driven only while its direction bit is one.
// - Each output pin shows its data-output latch bit.

`timescale 1ns/10ps

module gbs_gpio_set_clear
	import gbs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [4:0] p0_pin_i,
	output logic [4:0] p0_pin_o,
	output logic [4:0] p0_oe_n_o,
	input wire logic [1:0] p1_pin_i,
	output logic [1:0] p1_pin_o,
	output logic [1:0] p1_oe_n_o,
	input wire logic [6:0] p2_pin_i,
	output logic [6:0] p2_pin_o,
	output logic [6:0] p2_oe_n_o
);

	// ==========================================================
	// Address decode helpers
	function automatic gbs_acc_t acc_kind(input logic [31:0] a);
		case (a)
			ADR_P0_DATA, ADR_P1_DATA, ADR_P2_DATA: acc_kind = GBS_ACC_DATA;
			ADR_P0_SET, ADR_P1_SET, ADR_P2_SET: acc_kind = GBS_ACC_SET;
			ADR_P0_CLR, ADR_P1_CLR, ADR_P2_CLR: acc_kind = GBS_ACC_CLR;
			default: acc_kind = GBS_ACC_NONE;
		endcase
	endfunction

	function automatic logic [1:0] acc_port(input logic [31:0] a);
		case (a)
			ADR_P0_DATA, ADR_P0_SET, ADR_P0_CLR: acc_port = 2'h0;
			ADR_P1_DATA, ADR_P1_SET, ADR_P1_CLR: acc_port = 2'h1;
			default: acc_port = 2'h2;
		endcase
	endfunction

	function automatic logic [6:0] out_mask(input logic [1:0] p);
		case (p)
			2'h0: out_mask = P0_OUT_MASK;
			2'h1: out_mask = P1_OUT_MASK;
			default: out_mask = P2_OUT_MASK;
		endcase
	endfunction

	function automatic logic [6:0] dir_mask(input logic [1:0] p);
		case (p)
			2'h0: dir_mask = P0_DIR_MASK;
			2'h1: dir_mask = P1_DIR_MASK;
			default: dir_mask = P2_DIR_MASK;
		endcase
	endfunction

	// ==========================================================
	// Input synchronisers
	logic [2:0][6:0] sync1_r;
	logic [2:0][6:0] sync1_nxt;
	logic [2:0][6:0] sync2_r;
	logic [2:0][6:0] sync2_nxt;

	always_comb begin
		sync1_nxt[0] = {2'h0, p0_pin_i};
		sync1_nxt[1] = {5'h00, p1_pin_i};
		sync1_nxt[2] = p2_pin_i;
		sync2_nxt = sync1_r;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else if (ce_i) begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
		end
	end

	// ==========================================================
	// Bus request qualification
	gbs_acc_t kind;
	logic [1:0] port;
	logic [6:0] wr_pins;
	logic [6:0] wr_dirs;
	logic req_go;
	logic wr_go;
	logic rd_go;

	assign kind = acc_kind(wb_adr_i);
	assign port = acc_port(wb_adr_i);
	// Only the pin lanes are looked at; reserved bits are simply dropped
	assign wr_pins = wb_dat_i[OUT_LSB +: PIN_W] & out_mask(port);
	assign wr_dirs = wb_dat_i[DIR_LSB +: PIN_W] & dir_mask(port);
	assign req_go = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_go = req_go && wb_we_i;
	assign rd_go = req_go && !wb_we_i;

	// ==========================================================
	// Shared output latch and direction
	logic [2:0][6:0] out_r;
	logic [2:0][6:0] out_nxt;
	logic [2:0][6:0] dir_r;
	logic [2:0][6:0] dir_nxt;
	logic [2:0][6:0] oe_n_r;
	logic [2:0][6:0] oe_n_nxt;

	always_comb begin
		out_nxt = out_r;
		dir_nxt = dir_r;
		if (wr_go) begin
			case (kind)
				GBS_ACC_DATA: begin
					if (wb_sel_i[OUT_LANE]) begin
						out_nxt[port] = wr_pins;
					end
					if (wb_sel_i[DIR_LANE]) begin
						dir_nxt[port] = wr_dirs;
					end
				end
				GBS_ACC_SET: begin
					// OR keeps every zero bit as it was
					if (wb_sel_i[OUT_LANE]) begin
						out_nxt[port] = out_r[port] | wr_pins;
					end
				end
				GBS_ACC_CLR: begin
					if (wb_sel_i[OUT_LANE]) begin
						out_nxt[port] = out_r[port] & ~wr_pins;
					end
				end
				default: begin
					out_nxt = out_r;
				end
			endcase
		end
		for (int i = 0; i < 3; i++) begin
			oe_n_nxt[i] = ~(dir_nxt[i] & dir_mask(2'(i)));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_r <= {3{RST_OUT}};
			dir_r <= {3{RST_DIR}};
			oe_n_r <= '1;
		end else if (ce_i) begin
			out_r <= out_nxt;
			dir_r <= dir_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	// Pins come straight from the latch flops
	assign p0_pin_o = out_r[0][4:0];
	assign p1_pin_o = out_r[1][1:0];
	assign p2_pin_o = out_r[2];
	assign p0_oe_n_o = oe_n_r[0][4:0];
	assign p1_oe_n_o = oe_n_r[1][1:0];
	assign p2_oe_n_o = oe_n_r[2];

	// ==========================================================
	// Bus answer
	logic ack_r;
	logic ack_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	always_comb begin
		ack_nxt = req_go;
		rdata_nxt = RST_RDATA;
		if (rd_go) begin
			case (kind)
				GBS_ACC_DATA: begin
					rdata_nxt = {1'b0, dir_r[port], 1'b0, out_r[port], 9'h000,
						sync2_r[port] & dir_mask(port)};
				end
				GBS_ACC_SET, GBS_ACC_CLR: begin
					rdata_nxt = RST_RDATA;
				end
				default: begin
					rdata_nxt = RST_RDATA;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			rdata_r <= RST_RDATA;
		end else if (ce_i) begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

	// ==========================================================
	// Checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_set_port_zero: assert property (
		wr_go && kind == GBS_ACC_SET && port == 2'h0 && wb_sel_i[OUT_LANE]
		|=> (p0_pin_o & $past(wb_dat_i[20:16])) == $past(wb_dat_i[20:16]))
		else $error("port 0 set bit did not drive pin high");

	chk_set_port_one: assert property (
		wr_go && kind == GBS_ACC_SET && port == 2'h1 && wb_sel_i[OUT_LANE]
		|=> (p1_pin_o & $past(wb_dat_i[17:16])) == $past(wb_dat_i[17:16]))
		else $error("port 1 set bit did not drive pin high");

	chk_set_port_two: assert property (
		wr_go && kind == GBS_ACC_SET && port == 2'h2 && wb_sel_i[OUT_LANE]
		|=> (p2_pin_o & $past(wb_dat_i[22:16]) & P2_OUT_MASK)
			== ($past(wb_dat_i[22:16]) & P2_OUT_MASK))
		else $error("port 2 set bit did not drive pin high");

	chk_clr_port_zero: assert property (
		wr_go && kind == GBS_ACC_CLR && port == 2'h0 && wb_sel_i[OUT_LANE]
		|=> (p0_pin_o & $past(wb_dat_i[20:16])) == 5'h00)
		else $error("port 0 clear bit did not drive pin low");

	chk_clr_port_one: assert property (
		wr_go && kind == GBS_ACC_CLR && port == 2'h1 && wb_sel_i[OUT_LANE]
		|=> (p1_pin_o & $past(wb_dat_i[17:16])) == 2'h0)
		else $error("port 1 clear bit did not drive pin low");

	chk_clr_port_two: assert property (
		wr_go && kind == GBS_ACC_CLR && port == 2'h2 && wb_sel_i[OUT_LANE]
		|=> (p2_pin_o & $past(wb_dat_i[22:16]) & P2_OUT_MASK) == 7'h00)
		else $error("port 2 clear bit did not drive pin low");

	chk_zero_bits_hold: assert property (
		wr_go && (kind == GBS_ACC_SET || kind == GBS_ACC_CLR) && port == 2'h0
		|=> (p0_pin_o & ~$past(wb_dat_i[20:16])) == ($past(p0_pin_o) & ~$past(wb_dat_i[20:16])))
		else $error("zero bit of a set or clear write changed a pin");

	chk_other_ports_hold: assert property (
		wr_go && kind != GBS_ACC_DATA && port != 2'h2
		|=> p2_pin_o == $past(p2_pin_o) && p2_oe_n_o == $past(p2_oe_n_o))
		else $error("write to another port disturbed port 2");

	chk_dir_drives_oe: assert property (
		wr_go && kind == GBS_ACC_DATA && port == 2'h0 && wb_sel_i[DIR_LANE]
		|=> p0_oe_n_o == ~$past(wb_dat_i[28:24]))
		else $error("port 0 enable does not follow direction bits");

	chk_data_to_pin: assert property (
		wr_go && kind == GBS_ACC_DATA && port == 2'h1 && wb_sel_i[OUT_LANE]
		|=> p1_pin_o == $past(wb_dat_i[17:16]))
		else $error("port 1 pin does not show data output bits");

	chk_latch_readback: assert property (
		rd_go && kind == GBS_ACC_DATA && port == 2'h0
		|=> wb_ack_o && wb_dat_o[20:16] == p0_pin_o)
		else $error("data read does not show the shared latch");

	chk_wo_read_zero: assert property (
		rd_go && (kind == GBS_ACC_SET || kind == GBS_ACC_CLR)
		|=> wb_ack_o && wb_dat_o == 32'h0000_0000 && p0_pin_o == $past(p0_pin_o))
		else $error("set or clear read returned data or had an effect");

	chk_ack_one_cycle: assert property (
		ce_i && wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");

	chk_ack_after_take: assert property (
		req_go |=> wb_ack_o)
		else $error("taken request was not acknowledged next cycle");

	chk_idle_rdata_zero: assert property (
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero outside the ack cycle");

	// Pins 2..4 of port 2 have no output latch, pins 2..3 no direction
	chk_unused_pins_idle: assert property (
		p2_oe_n_o[3:2] == 2'h3 && p2_pin_o[4:2] == 3'h0)
		else $error("unused port 2 pin is driven");

endmodule

//--- bench/gbs_pin_partner.sv
// Purpose: External circuit on one GPIO port, resolves each pin's wire level
// Assumes: No pull on the pins; the far side drives only undriven pins
// Notes: ext_i is what the outside world puts on a pin the block has released
`timescale 1ns/10ps

module gbs_pin_partner #(
	parameter int W = 5
) (
	input wire logic [W-1:0] pin_o_i,
	input wire logic [W-1:0] oe_n_i,
	input wire logic [W-1:0] ext_i,
	output logic [W-1:0] lvl_o
);
	// ==========================================================
	// Wire resolution
	// Block owns the pin only while its enable is low
	assign lvl_o = (~oe_n_i & pin_o_i) | (oe_n_i & ext_i);
endmodule

//--- bench/gbs_gpio_set_clear_tb_top.sv
// Purpose: Random and corner tests of the GPIO set, clear and data registers
// Assumes: Classic Wishbone master, ce_i held high
// Notes: Set and clear writes keep reserved bits zero
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end

module gbs_gpio_set_clear_tb_top;
	import gbs_pkg::*;
	logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
	logic [3:0] wb_sel_i;
	logic [4:0] p0_o, p0_oe, l0, e0;
	logic [1:0] p1_o, p1_oe, l1, e1;
	logic [6:0] p2_o, p2_oe, l2, e2;
	logic [6:0] po[3], oe[3], lv[3], out_m[3], dir_m[3];
	logic [6:0] om[3] = '{P0_OUT_MASK, P1_OUT_MASK, P2_OUT_MASK};
	logic [6:0] dm[3] = '{P0_DIR_MASK, P1_DIR_MASK, P2_DIR_MASK};
	logic [31:0] ad[3] = '{ADR_P0_DATA, ADR_P1_DATA, ADR_P2_DATA};
	int failures, num_checks, seed, p;
	assign po = '{{2'b00, p0_o}, {5'h00, p1_o}, p2_o};
	assign oe = '{{2'b11, p0_oe}, {5'h1F, p1_oe}, p2_oe};
	assign lv = '{{2'b00, l0}, {5'h00, l1}, l2};

	// Expected data-register word from the model state and the wire levels
	function automatic logic [31:0] exp_word(input int k);
		exp_word = {1'b0, dir_m[k], 1'b0, out_m[k], 9'h000, lv[k] & dm[k]};
	endfunction

	gbs_gpio_set_clear u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.p0_pin_i(l0), .p0_pin_o(p0_o), .p0_oe_n_o(p0_oe),
		.p1_pin_i(l1), .p1_pin_o(p1_o), .p1_oe_n_o(p1_oe),
		.p2_pin_i(l2), .p2_pin_o(p2_o), .p2_oe_n_o(p2_oe));
	gbs_pin_partner #(.W(5)) u_ext0 (.pin_o_i(p0_o), .oe_n_i(p0_oe), .ext_i(e0), .lvl_o(l0));
	gbs_pin_partner #(.W(2)) u_ext1 (.pin_o_i(p1_o), .oe_n_i(p1_oe), .ext_i(e1), .lvl_o(l1));
	gbs_pin_partner #(.W(7)) u_ext2 (.pin_o_i(p2_o), .oe_n_i(p2_oe), .ext_i(e2), .lvl_o(l2));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task give_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Bus cycle: hold until ack is sampled, then one idle cycle
	task wb(input logic we, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 20) begin
			failures++;
			give_verdict();
		end
		@(posedge clk_i);
	endtask

	task check(input int k);
		wb(1'b0, ad[k], 32'h0000_0000);
		`CHK(q, exp_word(k))
		`CHK(po[k], out_m[k])
		`CHK(oe[k], ~dir_m[k])
		wb(1'b0, ad[k] + 32'h0000_0004, 32'h0000_0000);
		`CHK(q, 32'h0000_0000)
		wb(1'b0, ad[k] + 32'h0000_0008, 32'h0000_0000);
		`CHK(q, 32'h0000_0000)
	endtask

	// Kind 0 set, 1 clear, else whole data word
	task wr(input int k, input int op, input logic [31:0] r);
		logic [6:0] v;
		v = r[22:16] & om[k];
		if (op == 0) begin
			wb(1'b1, ad[k] + 32'h0000_0004, {9'h000, v, 16'h0000});
			if (wb_sel_i[OUT_LANE]) begin
				out_m[k] = out_m[k] | v;
			end
		end else if (op == 1) begin
			wb(1'b1, ad[k] + 32'h0000_0008, {9'h000, v, 16'h0000});
			if (wb_sel_i[OUT_LANE]) begin
				out_m[k] = out_m[k] & ~v;
			end
		end else begin
			wb(1'b1, ad[k], r & 32'h7F7F_007F);
			if (wb_sel_i[OUT_LANE]) begin
				out_m[k] = v;
			end
			// Port 2 keeps a direction bit for its input-only pin 4
			if (wb_sel_i[DIR_LANE]) begin
				dir_m[k] = r[30:24] & dm[k];
			end
		end
		check(k);
	endtask

	initial begin
		seed = 67451;
		rst_i = 1'b1;
		ce_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'b000;
		wb_adr_i = 32'h0000_0000;
		wb_dat_i = 32'h0000_0000;
		wb_sel_i = 4'hF;
		{e0, e1, e2} = 14'h0000;
		out_m = '{7'h00, 7'h00, 7'h00};
		dir_m = '{7'h00, 7'h00, 7'h00};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		for (p = 0; p < 3; p++) begin
			check(p);
			wr(p, 2, 32'h7F7F_0000);
			wr(p, 1, 32'h007F_0000);
			wr(p, 0, 32'h0001_0000);
			wr(p, 0, 32'h0000_0000);
			wr(p, 1, 32'h0000_0000);
		end
		$display("corner tests done");
		repeat (200) begin
			{e0, e1, e2} <= 14'($random(seed));
			wb_sel_i <= 4'($random(seed));
			wr({$random(seed)} % 3, {$random(seed)} % 3, $random(seed));
		end
		$display("random tests done");
		wb(1'b1, 32'hFFFF_0D2C, 32'hFFFF_FFFF);
		wb(1'b0, 32'hFFFF_0D2C, 32'h0000_0000);
		`CHK(q, 32'h0000_0000)
		for (p = 0; p < 3; p++) check(p);
		$display("unmapped tests done");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		out_m = '{7'h00, 7'h00, 7'h00};
		dir_m = '{7'h00, 7'h00, 7'h00};
		// Released pin levels need two edges through the synchroniser
		repeat (2) @(posedge clk_i);
		for (p = 0; p < 3; p++) check(p);
		$display("reset tests done");
		give_verdict();
	end
endmodule
